// [include/event_counter_pkg.sv]
// Constants, register map and state types of the event counting unit
//
// Overview of operation
// - In two-channel mode the lower wrap flag is set when the lower counter wraps from ff to 00.
// - The lower wrap flag clears only when software has read it as one and then writes zero to it.
// - The upper wrap flag is set whenever the upper counter wraps from ff to 00.
// - The upper wrap flag clears only when software has read it as one and then writes zero to it.
// - Software writes can only clear a wrap flag: a one leaves it unchanged, a zero clears it once it was read as one.
// - In single-channel mode the upper and lower counters form one 16-bit counter, else they run apart.
package event_counter_pkg;

   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 32;
   localparam int COUNT_W = 8;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_CTRL_STATUS = 8'h95;
   localparam logic [7:0] IDX_COUNT_UPPER = 8'h96;
   localparam logic [7:0] IDX_COUNT_LOWER = 8'h97;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h98;
   localparam logic [7:0] IDX_IRQ_CLEAR   = 8'h99;
   localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h9a;
   localparam int         IDX_LSB         = 2;

   // Field positions of event_counter_ctrl_status
   localparam int BIT_UPPER_WRAP   = 7;
   localparam int BIT_LOWER_WRAP   = 6;
   localparam int BIT_SPARE        = 5;
   localparam int BIT_CHANNEL_MODE = 4;
   localparam int BIT_UPPER_ENABLE = 3;
   localparam int BIT_LOWER_ENABLE = 2;
   localparam int BIT_UPPER_REL    = 1;
   localparam int BIT_LOWER_REL    = 0;

   // Field positions of the interrupt status, clear and enable registers
   localparam int IRQ_W         = 2;
   localparam int IRQ_BIT_LOWER = 0;
   localparam int IRQ_BIT_UPPER = 1;

   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_MAX   = 8'hff;
   localparam logic [7:0]         CTRL_RESET  = 8'h00;
   localparam logic [IRQ_W-1:0]   IRQ_RESET   = 2'h0;

   // Control bits that software writes directly
   typedef struct packed {
      logic spare;
      logic channelModeSelect;   // 1: two independent channels
      logic upperCountEnable;
      logic lowerCountEnable;
      logic upperResetRelease;
      logic lowerResetRelease;
   } ctrl_t;

   typedef struct packed {
      logic upperWrapFlag;
      logic lowerWrapFlag;
   } flags_t;

   // Whole state of the unit, registered as one word
   typedef struct packed {
      ctrl_t               ctrl;
      flags_t              flags;
      flags_t              armed;        // Flag was read as one
      logic [COUNT_W-1:0]  eventCountUpper;
      logic [COUNT_W-1:0]  eventCountLower;
      logic                prevUpper;
      logic                prevLower;
      logic [IRQ_W-1:0]    irqStatus;
      logic [IRQ_W-1:0]    irqEnable;
      logic                ack;
      logic [DATA_W-1:0]   readData;
      logic                irq;
   } state_t;

endpackage : event_counter_pkg

// [hdl/event_counting_unit.sv]
// Event counting unit: two 8-bit counters with a classic Wishbone slave
`timescale 1ns/1ps

module event_counting_unit (
   input  wire logic                                  sys_clk,
   input  wire logic                                  rst,
   input  wire logic                                  wb_cyc_i,
   input  wire logic                                  wb_stb_i,
   input  wire logic                                  wb_we_i,
   input  wire logic [event_counter_pkg::ADDR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                            wb_sel_i,
   input  wire logic [event_counter_pkg::DATA_W-1:0]  wb_dat_i,
   output logic      [event_counter_pkg::DATA_W-1:0]  wb_dat_o,
   output logic                                       wb_ack_o,
   input  wire logic                                  eventUpper,
   input  wire logic                                  eventLower,
   output logic                                       irq
);
   import event_counter_pkg::*;

   state_t s_q;
   state_t s_d;

   // Increment with carry out of the top bit
   function automatic logic [COUNT_W:0] bumpCount(
      input logic [COUNT_W-1:0] value
   );
      logic [COUNT_W:0] result;
      result = {1'b0, value} + {{COUNT_W{1'b0}}, 1'b1};
      return result;
   endfunction : bumpCount

   // Flag update: a hardware set outranks a software clear
   function automatic logic flagNext(
      input logic flag,
      input logic setEvent,
      input logic armedBit,
      input logic clearWrite,
      input logic writeBit
   );
      logic result;
      result = flag;
      if (clearWrite && armedBit && !writeBit) begin
         result = 1'b0;
      end
      if (setEvent) begin
         result = 1'b1;
      end
      return result;
   endfunction : flagNext

   // Register select: index match with the unused upper address bits at zero
   function automatic logic indexHit(
      input logic [ADDR_W-1:0] adr,
      input logic [7:0]        idx
   );
      logic result;
      result = (adr[ADDR_W-1:IDX_LSB+8] == '0)
               && (adr[IDX_LSB +: 8] == idx);
      return result;
   endfunction : indexHit

   // Next value of one counter half: held at zero until released
   function automatic logic [COUNT_W-1:0] halfNext(
      input logic [COUNT_W-1:0] count,
      input logic               released,
      input logic               step,
      input logic [COUNT_W:0]   bumped
   );
      logic [COUNT_W-1:0] result;
      result = count;
      if (!released) begin
         result = COUNT_RESET;
      end else if (step) begin
         result = bumped[COUNT_W-1:0];
      end
      return result;
   endfunction : halfNext

   // Control fields from the low byte of a write
   function automatic ctrl_t ctrlFromByte(
      input logic [7:0] data
   );
      ctrl_t result;
      result.spare             = data[BIT_SPARE];
      result.channelModeSelect = data[BIT_CHANNEL_MODE];
      result.upperCountEnable  = data[BIT_UPPER_ENABLE];
      result.lowerCountEnable  = data[BIT_LOWER_ENABLE];
      result.upperResetRelease = data[BIT_UPPER_REL];
      result.lowerResetRelease = data[BIT_LOWER_REL];
      return result;
   endfunction : ctrlFromByte

   // Reset image of the whole state
   localparam state_t STATE_RESET = '{
      ctrl:            CTRL_RESET[5:0],
      flags:           '0,
      armed:           '0,
      eventCountUpper: COUNT_RESET,
      eventCountLower: COUNT_RESET,
      // Edge history starts at the idle pin level: no false count
      prevUpper:       1'b0,
      prevLower:       1'b0,
      irqStatus:       IRQ_RESET,
      irqEnable:       IRQ_RESET,
      ack:             1'b0,
      readData:        '0,
      irq:             1'b0
   };

   logic             request;
   logic             accessDone;
   logic             lowByteWrite;
   logic             busTaken;
   logic             ctrlRead;
   logic             hitCtrl;
   logic             hitUpper;
   logic             hitLower;
   logic             hitIrqStatus;
   logic             hitIrqClear;
   logic             hitIrqEnable;
   logic [7:0]       ctrlStatusView;
   logic [DATA_W-1:0] readMux;
   logic             lowerEdge;
   logic             upperEdge;
   logic [COUNT_W:0] lowerBump;
   logic [COUNT_W:0] upperBump;
   logic             lowerStep;
   logic             upperStep;
   logic             lowerWrap;
   logic             upperWrap;
   logic             setLowerFlag;
   logic             setUpperFlag;
   logic             ctrlWrite;
   logic [IRQ_W-1:0] irqEvents;

   assign request      = wb_cyc_i && wb_stb_i;
   assign busTaken     = request && !s_q.ack;
   assign accessDone   = request && s_q.ack;
   assign lowByteWrite = accessDone && wb_we_i && wb_sel_i[0];
   assign hitCtrl      = indexHit(wb_adr_i, IDX_CTRL_STATUS);
   assign hitUpper     = indexHit(wb_adr_i, IDX_COUNT_UPPER);
   assign hitLower     = indexHit(wb_adr_i, IDX_COUNT_LOWER);
   assign hitIrqStatus = indexHit(wb_adr_i, IDX_IRQ_STATUS);
   assign hitIrqClear  = indexHit(wb_adr_i, IDX_IRQ_CLEAR);
   assign hitIrqEnable = indexHit(wb_adr_i, IDX_IRQ_ENABLE);
   assign ctrlWrite    = lowByteWrite && hitCtrl;
   assign ctrlRead     = accessDone && !wb_we_i && hitCtrl;

   always_comb begin
      ctrlStatusView                   = 8'h00;
      ctrlStatusView[BIT_UPPER_WRAP]   = s_q.flags.upperWrapFlag;
      ctrlStatusView[BIT_LOWER_WRAP]   = s_q.flags.lowerWrapFlag;
      ctrlStatusView[BIT_SPARE]        = s_q.ctrl.spare;
      ctrlStatusView[BIT_CHANNEL_MODE] = s_q.ctrl.channelModeSelect;
      ctrlStatusView[BIT_UPPER_ENABLE] = s_q.ctrl.upperCountEnable;
      ctrlStatusView[BIT_LOWER_ENABLE] = s_q.ctrl.lowerCountEnable;
      ctrlStatusView[BIT_UPPER_REL]    = s_q.ctrl.upperResetRelease;
      ctrlStatusView[BIT_LOWER_REL]    = s_q.ctrl.lowerResetRelease;
   end

   // Unmapped indices and the write-only clear register read as zero
   always_comb begin
      readMux = '0;
      if (hitCtrl) begin
         readMux[7:0] = ctrlStatusView;
      end else if (hitUpper) begin
         readMux[COUNT_W-1:0] = s_q.eventCountUpper;
      end else if (hitLower) begin
         readMux[COUNT_W-1:0] = s_q.eventCountLower;
      end else if (hitIrqStatus) begin
         readMux[IRQ_W-1:0] = s_q.irqStatus;
      end else if (hitIrqEnable) begin
         readMux[IRQ_W-1:0] = s_q.irqEnable;
      end
   end

   // Event inputs are synchronous; count on their rising edge
   assign lowerEdge = eventLower && !s_q.prevLower;
   assign upperEdge = eventUpper && !s_q.prevUpper;
   assign lowerBump = bumpCount(s_q.eventCountLower);
   assign upperBump = bumpCount(s_q.eventCountUpper);

   always_comb begin
      lowerStep = lowerEdge && s_q.ctrl.lowerCountEnable
                  && s_q.ctrl.lowerResetRelease;
      lowerWrap = lowerStep && lowerBump[COUNT_W];
      if (s_q.ctrl.channelModeSelect) begin
         upperStep = upperEdge && s_q.ctrl.upperCountEnable
                     && s_q.ctrl.upperResetRelease;
      end else begin
         // Upper byte advances on the carry out of the lower byte
         upperStep = lowerWrap && s_q.ctrl.upperCountEnable
                     && s_q.ctrl.upperResetRelease;
      end
      upperWrap = upperStep && upperBump[COUNT_W];
   end

   assign setLowerFlag = lowerWrap && s_q.ctrl.channelModeSelect;
   assign setUpperFlag = upperWrap;

   always_comb begin
      irqEvents                = '0;
      irqEvents[IRQ_BIT_LOWER] = setLowerFlag;
      irqEvents[IRQ_BIT_UPPER] = setUpperFlag;
   end

   always_comb begin
      s_d           = s_q;
      s_d.prevLower = eventLower;
      s_d.prevUpper = eventUpper;

      // Bus handshake: answer one cycle after the request, then drop
      s_d.ack = busTaken;
      if (busTaken) begin
         s_d.readData = readMux;
      end

      // Counters
      s_d.eventCountLower = halfNext(s_q.eventCountLower,
         s_q.ctrl.lowerResetRelease, lowerStep, lowerBump);
      s_d.eventCountUpper = halfNext(s_q.eventCountUpper,
         s_q.ctrl.upperResetRelease, upperStep, upperBump);

      // Arm a flag once a completed read of the register returned it as one
      if (ctrlRead) begin
         s_d.armed.upperWrapFlag = s_q.armed.upperWrapFlag
                                   || s_q.readData[BIT_UPPER_WRAP];
         s_d.armed.lowerWrapFlag = s_q.armed.lowerWrapFlag
                                   || s_q.readData[BIT_LOWER_WRAP];
      end

      if (ctrlWrite) begin
         s_d.ctrl  = ctrlFromByte(wb_dat_i[7:0]);
         // Any low-byte write to the control register ends the read-then-write sequence
         s_d.armed = '0;
      end

      // Writing one leaves a flag alone; zero clears only if armed
      s_d.flags.lowerWrapFlag = flagNext(s_q.flags.lowerWrapFlag,
         setLowerFlag, s_q.armed.lowerWrapFlag, ctrlWrite,
         wb_dat_i[BIT_LOWER_WRAP]);
      s_d.flags.upperWrapFlag = flagNext(s_q.flags.upperWrapFlag,
         setUpperFlag, s_q.armed.upperWrapFlag, ctrlWrite,
         wb_dat_i[BIT_UPPER_WRAP]);

      // Interrupt status: write-one-to-clear, new events win; enable is written directly
      if (lowByteWrite && hitIrqClear) begin
         s_d.irqStatus = s_q.irqStatus & ~wb_dat_i[IRQ_W-1:0];
      end else if (lowByteWrite && hitIrqEnable) begin
         s_d.irqEnable = wb_dat_i[IRQ_W-1:0];
      end
      s_d.irqStatus = s_d.irqStatus | irqEvents;
      s_d.irq       = |(s_d.irqStatus & s_d.irqEnable);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = s_q.readData;
   assign wb_ack_o = s_q.ack;
   assign irq      = s_q.irq;

endmodule : event_counting_unit

// [testbench/event_counter_sva.sv]
// Port checks of the event counting unit
`timescale 1ns/1ps
module event_counter_sva (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        eventUpper,
   input wire logic        eventLower,
   input wire logic        irq
);
   logic [5:0] mir_q;
   logic       clean_q;
   logic       acc;
   logic       rdCtl;
   assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
   assign rdCtl = acc && !wb_we_i && wb_adr_i == 32'h254;
   // Mirror of the control bits; clean until a half is first released
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mir_q   <= 6'h00;
         clean_q <= 1'b1;
      end else if (acc && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == 32'h254) begin
         mir_q   <= wb_dat_i[5:0];
         clean_q <= clean_q && wb_dat_i[1:0] == 2'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_hi;
      acc && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_lo_rel;
      acc && !wb_we_i && wb_adr_i == 32'h25c && !mir_q[0]
         |-> wb_dat_o == 32'h0;
   endproperty
   a_lo_rel: assert property (p_lo_rel) else $error("lower not held");
   property p_up_rel;
      acc && !wb_we_i && wb_adr_i == 32'h258 && !mir_q[1]
         |-> wb_dat_o == 32'h0;
   endproperty
   a_up_rel: assert property (p_up_rel) else $error("upper not held");
   property p_ctl;
      rdCtl |-> wb_dat_o[5:0] == mir_q;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control readback");
   property p_flags;
      rdCtl && clean_q |-> wb_dat_o[7:6] == 2'h0;
   endproperty
   a_flags: assert property (p_flags) else $error("flag with no wrap");
   property p_irq;
      clean_q |-> !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq with no event");
   c_irq: cover property ($rose(irq));
   c_lo: cover property (rdCtl && wb_dat_o[6]);
   c_up: cover property (rdCtl && wb_dat_o[7]);
endmodule : event_counter_sva

bind event_counting_unit event_counter_sva chkI (.sys_clk, .rst,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .eventUpper, .eventLower, .irq);

// [testbench/event_source.sv]
// External event pulse source for the counter inputs
`timescale 1ns/1ps
module event_source (
   input  wire logic sys_clk,
   output logic      eventUpper,
   output logic      eventLower
);
   initial begin
      eventUpper = 1'b0;
      eventLower = 1'b0;
   end
   // One cycle high, one low: the fastest rate the inputs take
   task automatic pulse(input logic upper, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         eventUpper <= upper;
         eventLower <= !upper;
         @(posedge sys_clk);
         eventUpper <= 1'b0;
         eventLower <= 1'b0;
      end
   endtask : pulse
endmodule : event_source

// [testbench/test_event_counting_unit.sv]
// Register-level regression of the event counting unit
`timescale 1ns/1ps
module test_event_counting_unit;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h0;
   logic [3:0]  selMask = 4'hf;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic        evU;
   logic        evL;
   int          nFail = 0;
   int          checksDone = 0;

   event_counting_unit DUT (.sys_clk, .rst, .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .eventUpper(evU), .eventLower(evL), .irq);
   event_source src (.sys_clk, .eventUpper(evU), .eventLower(evL));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
      @(posedge sys_clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= selMask;
      @(posedge sys_clk);
      while (ack !== 1'b1)
         @(posedge sys_clk);
      q = rdat;
      cyc <= 1'b0;
   endtask : wb

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rc(input string nm, input logic [31:0] a, e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask : rc

   task automatic results;
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   // Whole run is under two thousand cycles
   initial begin
      #60000;
      nFail++;
      results();
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rc("ctl", 32'h254, 32'h00);
      rc("up", 32'h258, 32'h00);
      rc("lo", 32'h25c, 32'h00);
      rc("ist", 32'h260, 32'h00);
      rc("iclr", 32'h264, 32'h00);
      wr(32'h300, 32'hff);
      rc("unmapped", 32'h300, 32'h00);
      wr(32'h254, 32'h1f);
      src.pulse(1'b0, 3);
      src.pulse(1'b1, 2);
      wr(32'h25c, 32'h77);
      rc("lo", 32'h25c, 32'h03);
      rc("up", 32'h258, 32'h02);
      wr(32'h268, 32'h03);
      src.pulse(1'b0, 253);
      rc("lo", 32'h25c, 32'h00);
      rc("ctl", 32'h254, 32'h5f);
      rc("ist", 32'h260, 32'h01);
      chk("irq", 32'(irq), 32'h1);
      wr(32'h254, 32'hdf);
      wr(32'h254, 32'h1f);
      rc("ctl", 32'h254, 32'h5f);
      wr(32'h254, 32'h1f);
      rc("ctl", 32'h254, 32'h1f);
      wr(32'h264, 32'h01);
      rc("ist", 32'h260, 32'h00);
      chk("irq", 32'(irq), 32'h0);
      src.pulse(1'b1, 254);
      rc("ctl", 32'h254, 32'h9f);
      wr(32'h268, 32'h00);
      rc("ien", 32'h268, 32'h00);
      chk("irq", 32'(irq), 32'h0);
      wr(32'h264, 32'h02);
      wr(32'h268, 32'h03);
      rc("ist", 32'h260, 32'h00);
      chk("irq", 32'(irq), 32'h0);
      wr(32'h254, 32'h1f);
      rc("ctl", 32'h254, 32'h1f);
      wr(32'h254, 32'h0f);
      src.pulse(1'b0, 257);
      src.pulse(1'b1, 3);
      rc("lo", 32'h25c, 32'h01);
      rc("up", 32'h258, 32'h01);
      rc("ctl", 32'h254, 32'h0f);
      wr(32'h254, 32'h33);
      rc("ctl", 32'h254, 32'h33);
      // Writes without byte lane 0 or with high address bits are ignored
      selMask = 4'he;
      wr(32'h254, 32'h00);
      selMask = 4'hf;
      wr(32'h400254, 32'h00);
      rc("alias", 32'h400254, 32'h00);
      rc("ctl", 32'h254, 32'h33);
      src.pulse(1'b0, 5);
      src.pulse(1'b1, 5);
      rc("lo", 32'h25c, 32'h01);
      rc("up", 32'h258, 32'h01);
      wr(32'h254, 32'h10);
      rc("lo", 32'h25c, 32'h00);
      rc("up", 32'h258, 32'h00);
      // Reset in mid-run must clear registers that now hold nonzero values
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rc("ctl", 32'h254, 32'h00);
      rc("ien", 32'h268, 32'h00);
      chk("irq", 32'(irq), 32'h0);
      results();
   end
endmodule : test_event_counting_unit
